/* shared/fspr_defs.svh */
// Bit positions, masks, command codes and timing of the status bank
`ifndef FSPR_DEFS_SVH
`define FSPR_DEFS_SVH
`define FSPR_BUSY_BIT     0
`define FSPR_WEL_BIT      1
`define FSPR_BP_LO        2
`define FSPR_BP_HI        6
`define FSPR_LOCK_LO_BIT  7
`define FSPR_LOCK_HI_BIT  8
`define FSPR_QE_BIT       9
`define FSPR_PSUS_BIT     10
`define FSPR_SEC_LO       11
`define FSPR_SEC_HI       13
`define FSPR_CMP_BIT      14
`define FSPR_ESUS_BIT     15
`define FSPR_DRV_LO       21
`define FSPR_DRV_HI       22
`define FSPR_HOLDRST_BIT  23
`define FSPR_DELIVERED    24'h400000
`define FSPR_NV_MASK      24'he07bfc
`define FSPR_SR1_MASK     24'h0000fc
`define FSPR_SR2_MASK     24'h007b00
`define FSPR_SR3_MASK     24'he00000
`define FSPR_ARRAY_BYTES  24'h800000
`define FSPR_SECT_UNIT    24'h001000
`define FSPR_BLK_UNIT     24'h020000
`define FSPR_C_WRSR1      8'h01
`define FSPR_C_WRSR2      8'h31
`define FSPR_C_WRSR3      8'h11
`define FSPR_C_WRITE_ENABLE_CMD       8'h06
`define FSPR_C_WRITE_DISABLE_CMD       8'h04
`define FSPR_C_SUSP       8'h75
`define FSPR_C_RESUME     8'h7a
`define FSPR_C_RST_EN     8'h66
`define FSPR_C_RST        8'h99
`define FSPR_C_PROG       8'h02
`define FSPR_C_QPROG      8'h32
`define FSPR_C_SECT       8'h20
`define FSPR_C_BLK32      8'h52
`define FSPR_C_BLK64      8'hd8
`define FSPR_C_CHIP_A     8'hc7
`define FSPR_C_CHIP_B     8'h60
`define FSPR_C_SEC_PROG   8'h42
`define FSPR_C_SEC_ERASE  8'h44
`define FSPR_STATUS_WRITE_CMD_NS      2000
`define FSPR_CLK_NS       10
`define FSPR_STATUS_WRITE_CMD_CYC     ((`FSPR_STATUS_WRITE_CMD_NS + `FSPR_CLK_NS - 1) / `FSPR_CLK_NS)
`endif

/* shared/fspr_pkg.sv */
// Types shared by the status bank and its surroundings
package fspr_pkg;
	typedef enum logic [2:0]
	{
		FSPR_OP_NONE      = 3'b000,
		FSPR_OP_PROG      = 3'b001,
		FSPR_OP_SECT      = 3'b010,
		FSPR_OP_BLK32     = 3'b011,
		FSPR_OP_BLK64     = 3'b100,
		FSPR_OP_CHIP      = 3'b101,
		FSPR_OP_SEC_PROG  = 3'b110,
		FSPR_OP_SEC_ERASE = 3'b111
	} fspr_op_t;

	typedef struct packed
	{
		logic [7:0]  code;
		logic [7:0]  data1;
		logic [7:0]  data2;
		logic        two_bytes;
		logic [23:0] addr;
	} fspr_cmd_t;

	typedef struct packed
	{
		fspr_op_t    kind;
		logic [23:0] addr;
	} fspr_op_req_t;
endpackage

/* src/fspr_regs.sv */
// Status and protection register bank of a serial NOR flash
//
// Functional notes
// - Config bit 23 selects hold (0) or reset (1) role for shared pin.
// - Quad enable set disables hold and reset; pin is data only.
// - Two strength bits pick read drive: 25, 50, 75 or 100 percent.
// - Suspend command sets erase- or program-suspended flag per active op.
// - Resume, software reset pair and power cycle clear both suspend flags.
// - Complement bit 14 is nonvolatile, read/write, default 0, joins protect.
// - Quad enable 0 keeps protect and hold/reset pins; 1 makes them data lines.
// - Lock bits 00: status write accepted when write-enable latch set.
// - Lock bits 01: write refused while protect pin low, else latch needed.
// - Lock bits 10: writes refused until power cycle, which restores 00.
// - Lock bits 11: status register permanently unwritable.
// - Program and erase aimed at protected region are rejected.
// - Protect bits writable only outside hardware-protected state.
// - Chip erase only with low protect bits 000/cmp 0 or 111/cmp 1.
// - Latch at 0 refuses status writes, programs and erases.
// - Busy bit 0 high during program, erase or status write.
// - Delivered state: all zero except bit 22.
// - Latch set by write enable, cleared by reset, disable and writes.
`timescale 1ns/10ps
`include "fspr_defs.svh"

module fspr_regs
#(
	parameter int STATUS_WRITE_CMD_CYCLES = `FSPR_STATUS_WRITE_CMD_CYC
)
(
	input  wire logic                  mclk_in,
	input  wire logic                  srst_in,
	input  wire logic                  link_clk_in,
	input  wire logic                  cmd_valid_in,
	input  wire fspr_pkg::fspr_cmd_t   cmd_in,
	input  wire logic                  wp_pin_in,
	input  wire logic [23:0]           nv_image_in,
	input  wire logic                  array_busy_in,
	input  wire fspr_pkg::fspr_op_t    array_kind_in,
	output logic [23:0]                link_status_out,
	output logic [23:0]                nv_image_out,
	output logic                       op_go_out,
	output fspr_pkg::fspr_op_req_t     op_out,
	output logic                       erase_susp_out,
	output logic                       prog_susp_out,
	output logic                       hold_en_out,
	output logic                       reset_en_out,
	output logic                       quad_mode_out,
	output logic [1:0]                 drive_code_out
);

	generate
		if (STATUS_WRITE_CMD_CYCLES < 1 || STATUS_WRITE_CMD_CYCLES > 65535)
		begin : g_bad
			$error("STATUS_WRITE_CMD_CYCLES out of range");
		end
	endgenerate

	localparam logic [15:0] STATUS_WRITE_CMD_LOAD = 16'(STATUS_WRITE_CMD_CYCLES);

	// =========================================================
	// Helpers
	function automatic logic fspr_protected(input logic [4:0] bp,
		input logic cmp, input logic [23:0] a);
		logic [23:0] size;
		logic        hit;
		logic [1:0]  sh;
		size = '0;
		hit  = 1'b0;
		sh   = 2'd0;
		if (bp[2:0] == 3'b111)
			hit = 1'b1;
		else if (bp[2:0] != 3'b000)
		begin
			if (bp[4])
			begin
				sh   = bp[2] ? 2'd3 : (bp[1:0] - 2'd1);
				size = `FSPR_SECT_UNIT << sh;
			end
			else
				size = `FSPR_BLK_UNIT << (bp[2:0] - 3'd1);
			hit = bp[3] ? (a < size) : (a >= (`FSPR_ARRAY_BYTES - size));
		end
		return hit ^ cmp;
	endfunction

	function automatic fspr_pkg::fspr_op_t fspr_decode(input logic [7:0] c);
		case (c)
			`FSPR_C_PROG, `FSPR_C_QPROG: return fspr_pkg::FSPR_OP_PROG;
			`FSPR_C_SECT:                return fspr_pkg::FSPR_OP_SECT;
			`FSPR_C_BLK32:               return fspr_pkg::FSPR_OP_BLK32;
			`FSPR_C_BLK64:               return fspr_pkg::FSPR_OP_BLK64;
			`FSPR_C_CHIP_A, `FSPR_C_CHIP_B: return fspr_pkg::FSPR_OP_CHIP;
			`FSPR_C_SEC_PROG:            return fspr_pkg::FSPR_OP_SEC_PROG;
			`FSPR_C_SEC_ERASE:           return fspr_pkg::FSPR_OP_SEC_ERASE;
			default:                     return fspr_pkg::FSPR_OP_NONE;
		endcase
	endfunction

	// =========================================================
	// Link domain: command capture and status mirror
	logic                 lrst_s1;
	logic                 lrst;
	logic                 req_tgl;
	fspr_pkg::fspr_cmd_t  cmd_hold;
	logic                 pub_s1;
	logic                 pub_s2;
	logic                 pub_seen;
	logic                 pub_tgl;
	logic [23:0]          pub_word;

	always_ff @(posedge link_clk_in)
	begin
		lrst_s1 <= srst_in;
		lrst    <= lrst_s1;
	end

	// Host frames are far apart, so the hold register is long stable
	// before the main clock samples it behind the toggle.
	always_ff @(posedge link_clk_in)
	begin
		if (lrst)
		begin
			req_tgl  <= 1'b0;
			cmd_hold <= '0;
		end
		else if (cmd_valid_in)
		begin
			req_tgl  <= ~req_tgl;
			cmd_hold <= cmd_in;
		end
	end

	always_ff @(posedge link_clk_in)
	begin
		if (lrst)
		begin
			pub_s1          <= 1'b0;
			pub_s2          <= 1'b0;
			pub_seen        <= 1'b0;
			link_status_out <= '0;
		end
		else
		begin
			pub_s1   <= pub_tgl;
			pub_s2   <= pub_s1;
			pub_seen <= pub_s2;
			if (pub_s2 != pub_seen)
				link_status_out <= pub_word;
		end
	end

	// =========================================================
	// Main domain: synchronisers and command decode
	logic                 req_s1;
	logic                 req_s2;
	logic                 req_s3;
	logic                 wp_s1;
	logic                 wp_s2;
	logic                 ack_s1;
	logic                 ack_s2;
	logic                 loaded;
	logic [23:0]          nv;
	logic                 write_enable_latch;
	logic                 busy_flag;
	logic                 esus;
	logic                 psus;
	logic                 rst_armed;
	logic [15:0]          status_write_cmd_cnt;

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
			wp_s1  <= 1'b0;
			wp_s2  <= 1'b0;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end
		else
		begin
			req_s1 <= req_tgl;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
			wp_s1  <= wp_pin_in;
			wp_s2  <= wp_s1;
			ack_s1 <= pub_seen;
			ack_s2 <= ack_s1;
		end
	end

	logic                 new_cmd;
	logic [7:0]           code;
	logic                 is_status_write_cmd;
	logic                 wp_level;
	logic [1:0]           lock;
	logic                 sr_allowed;
	logic                 status_write_cmd_take;
	fspr_pkg::fspr_op_t   kind;
	logic                 op_try;
	logic                 op_blocked;
	logic                 op_take;
	logic [23:0]          wmask;
	logic [23:0]          wdat;
	logic [23:0]          next_nv;
	logic [1:0]           sidx;
	logic                 sw_reset;

	assign new_cmd  = (req_s2 ^ req_s3) & loaded;
	assign code     = cmd_hold.code;
	assign lock     = {nv[`FSPR_LOCK_HI_BIT], nv[`FSPR_LOCK_LO_BIT]};
	// Protect pin is a data line in quad mode, so it cannot lock
	assign wp_level = nv[`FSPR_QE_BIT] | wp_s2;
	assign sr_allowed = (lock == 2'b00)
		| ((lock == 2'b01) & wp_level);
	assign is_status_write_cmd  = new_cmd & ((code == `FSPR_C_WRSR1)
		| (code == `FSPR_C_WRSR2) | (code == `FSPR_C_WRSR3));
	assign status_write_cmd_take = is_status_write_cmd & write_enable_latch & ~busy_flag & sr_allowed;
	assign kind     = fspr_decode(code);
	assign op_try   = new_cmd & (kind != fspr_pkg::FSPR_OP_NONE)
		& write_enable_latch & ~busy_flag;
	assign sidx     = cmd_hold.addr[13:12];
	assign sw_reset = new_cmd & rst_armed & (code == `FSPR_C_RST);

	always_comb
	begin
		case (kind)
			fspr_pkg::FSPR_OP_CHIP:
				op_blocked = ~(((nv[4:2] == 3'b000) & ~nv[`FSPR_CMP_BIT])
					| ((nv[4:2] == 3'b111) & nv[`FSPR_CMP_BIT]));
			fspr_pkg::FSPR_OP_SEC_PROG, fspr_pkg::FSPR_OP_SEC_ERASE:
				op_blocked = (sidx == 2'd0)
					| nv[`FSPR_SEC_LO + 32'(sidx) - 1];
			default:
				op_blocked = fspr_protected(nv[`FSPR_BP_HI:`FSPR_BP_LO],
					nv[`FSPR_CMP_BIT], cmd_hold.addr);
		endcase
	end
	assign op_take = op_try & ~op_blocked;

	always_comb
	begin
		case (code)
			`FSPR_C_WRSR2:
			begin
				wmask = `FSPR_SR2_MASK;
				wdat  = {8'h00, cmd_hold.data1, 8'h00};
			end
			`FSPR_C_WRSR3:
			begin
				wmask = `FSPR_SR3_MASK;
				wdat  = {cmd_hold.data1, 16'h0000};
			end
			default:
			begin
				wmask = cmd_hold.two_bytes
					? (`FSPR_SR1_MASK | `FSPR_SR2_MASK) : `FSPR_SR1_MASK;
				wdat  = {8'h00, cmd_hold.data2, cmd_hold.data1};
			end
		endcase
		next_nv = (nv & ~wmask) | (wdat & wmask);
		next_nv[`FSPR_SEC_HI:`FSPR_SEC_LO] = next_nv[`FSPR_SEC_HI:`FSPR_SEC_LO]
			| nv[`FSPR_SEC_HI:`FSPR_SEC_LO];
	end

	// =========================================================
	// Nonvolatile bits
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			nv     <= `FSPR_DELIVERED;
			loaded <= 1'b0;
		end
		else if (!loaded)
		begin
			// Stored image comes back; a power-down lock reopens
			nv     <= nv_image_in & `FSPR_NV_MASK;
			loaded <= 1'b1;
			if (nv_image_in[`FSPR_LOCK_HI_BIT]
				& ~nv_image_in[`FSPR_LOCK_LO_BIT])
				nv[`FSPR_LOCK_HI_BIT] <= 1'b0;
		end
		else if (status_write_cmd_take)
			nv <= next_nv & `FSPR_NV_MASK;
	end

	// =========================================================
	// Volatile flags and busy timer
	always_ff @(posedge mclk_in)
	begin
		if (srst_in || sw_reset)
			write_enable_latch <= 1'b0;
		else if (new_cmd && code == `FSPR_C_WRITE_ENABLE_CMD)
			write_enable_latch <= 1'b1;
		else if ((new_cmd && code == `FSPR_C_WRITE_DISABLE_CMD) || op_try
			|| (is_status_write_cmd && write_enable_latch && !busy_flag))
			write_enable_latch <= 1'b0;
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			rst_armed <= 1'b0;
		else if (new_cmd)
			rst_armed <= (code == `FSPR_C_RST_EN);
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in || sw_reset || (new_cmd && code == `FSPR_C_RESUME))
		begin
			esus <= 1'b0;
			psus <= 1'b0;
		end
		else if (new_cmd && code == `FSPR_C_SUSP && array_busy_in)
		begin
			if (array_kind_in == fspr_pkg::FSPR_OP_PROG
				|| array_kind_in == fspr_pkg::FSPR_OP_SEC_PROG)
				psus <= 1'b1;
			else
				esus <= 1'b1;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			status_write_cmd_cnt  <= 16'h0000;
			busy_flag <= 1'b0;
		end
		else
		begin
			if (status_write_cmd_take)
				status_write_cmd_cnt <= STATUS_WRITE_CMD_LOAD;
			else if (status_write_cmd_cnt != 16'h0000)
				status_write_cmd_cnt <= status_write_cmd_cnt - 16'h0001;
			busy_flag <= array_busy_in | (status_write_cmd_cnt != 16'h0000)
				| status_write_cmd_take;
		end
	end

	// =========================================================
	// Status word publish toward the link
	logic [23:0] cur_word;

	always_comb
	begin
		cur_word = nv & `FSPR_NV_MASK;
		cur_word[`FSPR_BUSY_BIT] = busy_flag;
		cur_word[`FSPR_WEL_BIT]  = write_enable_latch;
		cur_word[`FSPR_PSUS_BIT] = psus;
		cur_word[`FSPR_ESUS_BIT] = esus;
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			pub_tgl  <= 1'b0;
			pub_word <= '0;
		end
		else if (ack_s2 == pub_tgl && cur_word != pub_word)
		begin
			pub_word <= cur_word;
			pub_tgl  <= ~pub_tgl;
		end
	end

	// =========================================================
	// Pin roles and operation grants
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			hold_en_out    <= 1'b0;
			reset_en_out   <= 1'b0;
			quad_mode_out  <= 1'b0;
			drive_code_out <= 2'b10;
			erase_susp_out <= 1'b0;
			prog_susp_out  <= 1'b0;
			nv_image_out   <= `FSPR_DELIVERED;
		end
		else
		begin
			hold_en_out    <= ~nv[`FSPR_QE_BIT]
				& ~nv[`FSPR_HOLDRST_BIT];
			reset_en_out   <= ~nv[`FSPR_QE_BIT]
				& nv[`FSPR_HOLDRST_BIT];
			quad_mode_out  <= nv[`FSPR_QE_BIT];
			drive_code_out <= nv[`FSPR_DRV_HI:`FSPR_DRV_LO];
			erase_susp_out <= esus;
			prog_susp_out  <= psus;
			nv_image_out   <= nv;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			op_go_out <= 1'b0;
			op_out    <= '0;
		end
		else
		begin
			op_go_out <= op_take;
			if (op_take)
				op_out <= '{kind: kind, addr: cmd_hold.addr};
		end
	end

	// =========================================================
	// Checks
	wel_needed_a:
	assert property (@(posedge mclk_in) disable iff (srst_in)
		op_go_out |-> $past(write_enable_latch, 1))
	else $error("operation granted without write enable");

	busy_status_write_cmd_a:
	assert property (@(posedge mclk_in) disable iff (srst_in)
		status_write_cmd_take |=> busy_flag [*2])
	else $error("busy not raised by status write");

	pin_role_a:
	assert property (@(posedge mclk_in) disable iff (srst_in)
		!(hold_en_out && reset_en_out))
	else $error("hold and reset both enabled");

	quad_pins_a:
	assert property (@(posedge mclk_in) disable iff (srst_in)
		quad_mode_out |-> !hold_en_out && !reset_en_out)
	else $error("hold or reset active in quad mode");

	hw_lock_a:
	assert property (@(posedge mclk_in) disable iff (srst_in)
		(lock == 2'b01 && !wp_level) |-> !status_write_cmd_take)
	else $error("status write taken under hardware lock");

	hard_lock_a:
	assert property (@(posedge mclk_in) disable iff (srst_in)
		lock[1] && loaded |=> $stable(nv))
	else $error("locked status register changed");

	chip_erase_a:
	assert property (@(posedge mclk_in) disable iff (srst_in)
		op_go_out && op_out.kind == fspr_pkg::FSPR_OP_CHIP
		|-> $past(nv[`FSPR_CMP_BIT]) ? ($past(nv[4:2]) == 3'b111)
		: ($past(nv[4:2]) == 3'b000))
	else $error("chip erase granted under protection");

	susp_clear_a:
	assert property (@(posedge mclk_in) disable iff (srst_in)
		new_cmd && code == `FSPR_C_RESUME |=> !esus && !psus)
	else $error("suspend flag survived resume");

	secreg_otp_a:
	assert property (@(posedge mclk_in) disable iff (srst_in)
		loaded && $past(loaded) |-> (($past(nv[`FSPR_SEC_HI:`FSPR_SEC_LO])
		& ~nv[`FSPR_SEC_HI:`FSPR_SEC_LO]) == 3'b000))
	else $error("security lock bit cleared");

	reserved_zero_a:
	assert property (@(posedge mclk_in) disable iff (srst_in)
		pub_word[20:16] == 5'h00)
	else $error("reserved status bits not zero");
endmodule

/* sim/fspr_host_model.sv */
// Behavioural host controller issuing decoded frames on the link
`timescale 1ns/10ps

module fspr_host_model
(
	input  wire logic                link_clk_in,
	input  wire logic [23:0]         status_in,
	output logic                     cmd_valid_out,
	output fspr_pkg::fspr_cmd_t      cmd_out
);
	initial
	begin
		cmd_valid_out = 1'b0;
		cmd_out = '0;
	end

	// ==========================================
	// Frame issue
	task automatic send(input logic [7:0] code, input logic [7:0] d1,
		input logic [7:0] d2, input logic two, input logic [23:0] a);
		@(posedge link_clk_in);
		cmd_valid_out <= 1'b1;
		cmd_out <= '{code, d1, d2, two, a};
		@(posedge link_clk_in);
		cmd_valid_out <= 1'b0;
		// Released lines flip so a stale frame cannot look valid
		cmd_out <= ~cmd_out;
		repeat (2) @(posedge link_clk_in);
	endtask

	// ==========================================
	// Busy polling
	// Each poll is a fresh status sample
	task automatic wait_idle(output logic seen, output logic hung);
		int n;
		seen = 1'b0;
		hung = 1'b1;
		for (n = 0; n < 24; n++)
		begin
			@(posedge link_clk_in);
			if (status_in[0] === 1'b1)
				seen = 1'b1;
			if (n >= 6 && status_in[0] === 1'b0)
			begin
				hung = 1'b0;
				break;
			end
		end
	endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench for the status and protection register bank
`timescale 1ns/10ps
`include "fspr_defs.svh"

module testbench;
	logic                     mclk_in;
	logic                     srst_in;
	logic                     link_clk;
	logic                     cmd_valid;
	fspr_pkg::fspr_cmd_t      cmd;
	logic                     wp_pin;
	logic [23:0]              nv_in;
	logic                     arr_busy;
	fspr_pkg::fspr_op_t       arr_kind;
	logic [23:0]              link_status;
	logic [23:0]              nv_out;
	logic                     op_go;
	fspr_pkg::fspr_op_req_t   op;
	logic                     esus;
	logic                     psus;
	logic                     hold_en;
	logic                     reset_en;
	logic                     quad;
	logic [1:0]               drv;
	logic                     seen;
	logic                     hung;
	int                       error_cnt;
	int                       samples_checked;
	int                       go_cnt;
	int                       cyc;

	// Short busy time, still longer than three link clocks
	fspr_regs #(.STATUS_WRITE_CMD_CYCLES(40)) u_fspr_regs
	(
		.mclk_in(mclk_in), .srst_in(srst_in), .link_clk_in(link_clk),
		.cmd_valid_in(cmd_valid), .cmd_in(cmd), .wp_pin_in(wp_pin),
		.nv_image_in(nv_in), .array_busy_in(arr_busy),
		.array_kind_in(arr_kind), .link_status_out(link_status),
		.nv_image_out(nv_out), .op_go_out(op_go), .op_out(op),
		.erase_susp_out(esus), .prog_susp_out(psus),
		.hold_en_out(hold_en), .reset_en_out(reset_en),
		.quad_mode_out(quad), .drive_code_out(drv)
	);

	fspr_host_model u_fspr_host_model
	(
		.link_clk_in(link_clk), .status_in(link_status),
		.cmd_valid_out(cmd_valid), .cmd_out(cmd)
	);

	// ==========================================
	// Clocks, grant monitor, timeout
	initial
	begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end

	initial
	begin
		link_clk = 1'b0;
		#3.3;
		forever #62.5 link_clk = ~link_clk;
	end

	always @(posedge mclk_in)
	begin
		cyc++;
		if (op_go === 1'b1)
			go_cnt++;
		if (cyc == 60000)
		begin
			error_cnt++;
			summarize();
		end
	end

	// ==========================================
	// Helpers
	task automatic chk(input string name, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask

	// Latch bit left out: refused writes may or may not clear it
	task automatic stat(input logic [23:0] e);
		chk("status", 32'(e & 24'hfffffd), 32'(link_status & 24'hfffffd));
	endtask

	task automatic idle();
		u_fspr_host_model.wait_idle(seen, hung);
		if (hung !== 1'b0)
			chk("idle", 32'h0, 32'h1);
	endtask

	task automatic write_enable_cmd();
		u_fspr_host_model.send(`FSPR_C_WRITE_ENABLE_CMD, 8'h00, 8'h00, 1'b0, 24'h0);
	endtask

	task automatic wr(input logic [7:0] code, input logic [7:0] d1,
		input logic [7:0] d2, input logic two);
		write_enable_cmd();
		u_fspr_host_model.send(code, d1, d2, two, 24'h0);
		idle();
	endtask

	task automatic arr(input logic [7:0] code, input logic [23:0] a,
		input fspr_pkg::fspr_op_t k, input logic go, input logic en);
		int g;
		g = go_cnt;
		if (en)
			write_enable_cmd();
		u_fspr_host_model.send(code, 8'h00, 8'h00, 1'b0, a);
		idle();
		chk("grants", 32'(go), 32'(go_cnt - g));
		if (go)
			chk("op", 32'({k, a}), 32'(op));
	endtask

	task automatic susp(input logic [7:0] code, input logic [1:0] e);
		u_fspr_host_model.send(code, 8'h00, 8'h00, 1'b0, 24'h0);
		repeat (6) @(posedge link_clk);
		chk("suspend", 32'({e, e}),
			32'({esus, psus, link_status[15], link_status[10]}));
	endtask

	task automatic pwr(input logic [23:0] img);
		@(posedge mclk_in);
		nv_in <= img;
		srst_in <= 1'b1;
		repeat (4) @(posedge link_clk);
		@(posedge mclk_in);
		srst_in <= 1'b0;
		// Mirror updates follow: delivered word, then stored image if it differs
		repeat (10) @(posedge link_clk);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================
	// Tests
	initial
	begin
		error_cnt = 0;
		samples_checked = 0;
		go_cnt = 0;
		cyc = 0;
		srst_in = 1'b1;
		wp_pin = 1'b1;
		nv_in = `FSPR_DELIVERED;
		arr_busy = 1'b0;
		arr_kind = fspr_pkg::FSPR_OP_NONE;
		pwr(`FSPR_DELIVERED);
		stat(24'h400000);
		chk("drive", 32'h2, 32'(drv));
		chk("pins", 32'h2, 32'({quad, hold_en, reset_en}));
		$display("test delivered state done");

		u_fspr_host_model.send(`FSPR_C_WRSR1, 8'h1c, 8'h00, 1'b0, 24'h0);
		idle();
		stat(24'h400000);
		write_enable_cmd();
		idle();
		chk("latch", 32'h400002, 32'(link_status));
		u_fspr_host_model.send(`FSPR_C_WRSR1, 8'h1f, 8'h42, 1'b1, 24'h0);
		idle();
		chk("busy seen", 32'h1, 32'(seen));
		chk("after write", 32'h40421c, 32'(link_status));
		chk("nv", 32'h40421c, 32'(nv_out));
		chk("pins", 32'h4, 32'({quad, hold_en, reset_en}));
		arr(`FSPR_C_CHIP_A, 24'h0, fspr_pkg::FSPR_OP_CHIP, 1'b1, 1'b1);
		arr(`FSPR_C_PROG, 24'h7ff000, fspr_pkg::FSPR_OP_PROG, 1'b1, 1'b1);
		$display("test write enable done");

		for (int i = 0; i < 4; i++)
		begin
			wr(`FSPR_C_WRSR3, {1'b0, 2'(i), 5'h1f}, 8'h00, 1'b0);
			chk("drive", 32'(i), 32'(drv));
			stat({1'b0, 2'(i), 21'h00421c});
		end
		wr(`FSPR_C_WRSR3, 8'h80, 8'h00, 1'b0);
		chk("pins", 32'h4, 32'({quad, hold_en, reset_en}));
		wr(`FSPR_C_WRSR2, 8'h40, 8'h00, 1'b0);
		stat(24'h80401c);
		chk("pins", 32'h1, 32'({quad, hold_en, reset_en}));
		$display("test config bits done");

		@(posedge mclk_in);
		arr_busy <= 1'b1;
		arr_kind <= fspr_pkg::FSPR_OP_SECT;
		susp(`FSPR_C_SUSP, 2'b10);
		susp(`FSPR_C_RESUME, 2'b00);
		@(posedge mclk_in);
		arr_kind <= fspr_pkg::FSPR_OP_PROG;
		susp(`FSPR_C_SUSP, 2'b01);
		u_fspr_host_model.send(`FSPR_C_RST_EN, 8'h00, 8'h00, 1'b0, 24'h0);
		susp(`FSPR_C_RST, 2'b00);
		@(posedge mclk_in);
		arr_busy <= 1'b0;
		$display("test suspend done");

		wr(`FSPR_C_WRSR1, 8'h04, 8'h00, 1'b0);
		wr(`FSPR_C_WRSR2, 8'h00, 8'h00, 1'b0);
		stat(24'h800004);
		arr(`FSPR_C_SECT, 24'h7f0000, fspr_pkg::FSPR_OP_SECT, 1'b0, 1'b1);
		arr(`FSPR_C_PROG, 24'h100000, fspr_pkg::FSPR_OP_PROG, 1'b1, 1'b1);
		arr(`FSPR_C_CHIP_B, 24'h0, fspr_pkg::FSPR_OP_CHIP, 1'b0, 1'b1);
		arr(`FSPR_C_PROG, 24'h100000, fspr_pkg::FSPR_OP_PROG, 1'b0, 1'b0);
		$display("test protection done");

		wr(`FSPR_C_WRSR1, 8'h84, 8'h00, 1'b0);
		@(posedge mclk_in);
		wp_pin <= 1'b0;
		wr(`FSPR_C_WRSR1, 8'h80, 8'h00, 1'b0);
		stat(24'h800084);
		@(posedge mclk_in);
		wp_pin <= 1'b1;
		wr(`FSPR_C_WRSR1, 8'h80, 8'h00, 1'b0);
		stat(24'h800080);
		wr(`FSPR_C_WRSR1, 8'h00, 8'h01, 1'b1);
		wr(`FSPR_C_WRSR1, 8'h1c, 8'h00, 1'b1);
		stat(24'h800100);
		pwr(24'h800100);
		stat(24'h800000);
		wr(`FSPR_C_WRSR2, 8'h08, 8'h00, 1'b0);
		stat(24'h800800);
		wr(`FSPR_C_WRSR2, 8'h00, 8'h00, 1'b0);
		stat(24'h800800);
		$display("test locks done");

		write_enable_cmd();
		u_fspr_host_model.send(`FSPR_C_WRITE_DISABLE_CMD, 8'h00, 8'h00, 1'b0, 24'h0);
		idle();
		chk("latch", 32'h800800, 32'(link_status));
		arr(`FSPR_C_SEC_PROG, 24'h001000, fspr_pkg::FSPR_OP_SEC_PROG,
			1'b0, 1'b1);
		arr(`FSPR_C_SEC_ERASE, 24'h002000, fspr_pkg::FSPR_OP_SEC_ERASE,
			1'b1, 1'b1);
		arr(`FSPR_C_BLK64, 24'h010000, fspr_pkg::FSPR_OP_BLK64,
			1'b1, 1'b1);
		wr(`FSPR_C_WRSR1, 8'h80, 8'h01, 1'b1);
		wr(`FSPR_C_WRSR1, 8'h00, 8'h00, 1'b1);
		stat(24'h800980);
		pwr(24'h800980);
		stat(24'h800980);
		$display("test extra commands done");
		summarize();
	end
endmodule
